//--- core/i2c_slave_cfg.sv
// Two-wire slave: address match, speed mode, configuration decoding
`timescale 1ns/100ps
`include "i2c_cfg_params.svh"
module i2c_slave_cfg (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  input  wire logic                  i_ce,
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  input  wire logic                  i_addr_select_pin,
  input  wire logic [7:0]            i_rd_data,
  output logic                       o_sda,
  output logic                       o_sda_oe,
  output logic                       o_hs_mode,
  output logic                       o_busy,
  output logic                       o_rd_req,
  output logic                       o_setup_wr,
  output logic [7:0]                 o_setup_byte,
  output logic [7:0]                 o_conv_configuration,
  output i2c_cfg_pkg::conv_cfg_t     o_cfg,
  output logic                       o_mon_rate_free
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] scl_sync_ff;             // SCL two-stage synchroniser
  logic [1:0] sda_sync_ff;             // SDA two-stage synchroniser
  logic       scl_d_ff;                // Delayed synchronised SCL
  logic       sda_d_ff;                // Delayed synchronised SDA
  logic [1:0] asel_sync_ff;            // Address select synchroniser

  // Second stage only is read by logic
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_sync_ff  <= 2'h3;
      sda_sync_ff  <= 2'h3;
      scl_d_ff     <= 1'b1;
      sda_d_ff     <= 1'b1;
      asel_sync_ff <= 2'h0;
    end else if (i_ce) begin
      scl_sync_ff  <= {scl_sync_ff[0], i_scl};
      sda_sync_ff  <= {sda_sync_ff[0], i_sda};
      scl_d_ff     <= scl_sync_ff[1];
      sda_d_ff     <= sda_sync_ff[1];
      asel_sync_ff <= {asel_sync_ff[0], i_addr_select_pin};
    end
  end

  logic scl_s;                         // Synchronised SCL
  logic sda_s;                         // Synchronised SDA
  logic scl_rise;                      // SCL rising edge
  logic scl_fall;                      // SCL falling edge
  logic start_det;                     // START or repeated START
  logic stop_det;                      // STOP
  assign scl_s     = scl_sync_ff[1];
  assign sda_s     = sda_sync_ff[1];
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  ////////////////////////////////////////////////////////////////////
  // Byte decode helpers
  function automatic logic addr_match(input logic [6:0] a, input logic pin);
    // Upper six bits fixed, lowest bit from the select pin
    addr_match = (a == {`ADDR_BASE, pin});
  endfunction

  function automatic logic is_hs_code(input logic [7:0] b);
    is_hs_code = (b[7:3] == `HS_CODE_TOP);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Protocol state machine
  i2c_cfg_pkg::state_t state_ff;       // Current state
  logic [7:0] shift_ff;                // Receive shift register
  logic [3:0] bit_cnt_ff;              // Bit counter in byte
  logic       is_addr_ff;              // Byte in ACK slot was address
  logic       ack_ff;                  // Drive ACK in current slot
  logic       hs_ff;                   // High-speed mode flag
  logic       hs_code_seen_ff;         // Master code just received
  logic [7:0] tx_ff;                   // Transmit shift register
  logic       rd_dir_ff;               // Addressed for read
  logic       sda_drive_ff;            // Registered SDA low drive
  logic       master_ack_ff;           // Master acked last read byte
  logic [7:0] setup_ff;                // Last setup byte
  logic       setup_wr_ff;             // Setup write pulse
  logic       rd_req_ff;               // Read byte request pulse
  logic [7:0] cfg_ff;                  // Configuration register

  // Main sequencing, edge by edge on the sampled bus
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff        <= i2c_cfg_pkg::ST_IDLE;
      shift_ff        <= 8'h00;
      bit_cnt_ff      <= 4'h0;
      is_addr_ff      <= 1'b0;
      ack_ff          <= 1'b0;
      hs_ff           <= 1'b0;
      hs_code_seen_ff <= 1'b0;
      tx_ff           <= 8'hFF;
      rd_dir_ff       <= 1'b0;
      sda_drive_ff    <= 1'b0;
      master_ack_ff   <= 1'b0;
      setup_ff        <= 8'h00;
      setup_wr_ff     <= 1'b0;
      rd_req_ff       <= 1'b0;
    end else if (i_ce) begin
      setup_wr_ff <= 1'b0;
      rd_req_ff   <= 1'b0;
      if (stop_det) begin
        // Bus released: back to fast timing
        state_ff     <= i2c_cfg_pkg::ST_IDLE;
        sda_drive_ff <= 1'b0;
        hs_ff        <= 1'b0;
      end else if (start_det) begin
        // Repeated START keeps speed mode unchanged
        state_ff     <= i2c_cfg_pkg::ST_ADDR;
        bit_cnt_ff   <= 4'h0;
        sda_drive_ff <= 1'b0;
        if (hs_code_seen_ff) begin
          hs_ff <= 1'b1;
        end
        hs_code_seen_ff <= 1'b0;
      end else begin
        case (state_ff)
          i2c_cfg_pkg::ST_IDLE: begin
            sda_drive_ff <= 1'b0;
          end
          i2c_cfg_pkg::ST_ADDR,
          i2c_cfg_pkg::ST_WR: begin
            if (scl_rise) begin
              shift_ff   <= {shift_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              is_addr_ff <= (state_ff == i2c_cfg_pkg::ST_ADDR);
              if (state_ff == i2c_cfg_pkg::ST_ADDR) begin
                if (addr_match(shift_ff[7:1], asel_sync_ff[1])) begin
                  ack_ff       <= 1'b1;
                  rd_dir_ff    <= shift_ff[0];
                  sda_drive_ff <= 1'b1;
                  state_ff     <= i2c_cfg_pkg::ST_ACK;
                end else if (is_hs_code(shift_ff)) begin
                  // Master code: leave SDA released for the slot
                  ack_ff          <= 1'b0;
                  hs_code_seen_ff <= 1'b1;
                  state_ff        <= i2c_cfg_pkg::ST_ACK;
                end else begin
                  state_ff <= i2c_cfg_pkg::ST_IDLE;
                end
              end else begin
                ack_ff       <= 1'b1;
                sda_drive_ff <= 1'b1;
                state_ff     <= i2c_cfg_pkg::ST_ACK;
                if (shift_ff[7]) begin
                  setup_ff    <= shift_ff;
                  setup_wr_ff <= 1'b1;
                end
              end
            end
          end
          i2c_cfg_pkg::ST_ACK: begin
            if (scl_fall) begin
              ack_ff     <= 1'b0;
              bit_cnt_ff <= 4'h0;
              if (hs_code_seen_ff) begin
                // Wait for repeated START after the not-acknowledge
                sda_drive_ff <= 1'b0;
                hs_ff        <= 1'b1;
                state_ff     <= i2c_cfg_pkg::ST_IDLE;
              end else if (is_addr_ff && rd_dir_ff) begin
                tx_ff        <= i_rd_data;
                rd_req_ff    <= 1'b1;
                sda_drive_ff <= ~i_rd_data[7];
                state_ff     <= i2c_cfg_pkg::ST_RD;
              end else begin
                sda_drive_ff <= 1'b0;
                state_ff     <= i2c_cfg_pkg::ST_WR;
              end
            end
          end
          i2c_cfg_pkg::ST_RD: begin
            if (scl_fall) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                sda_drive_ff <= 1'b0;
                state_ff     <= i2c_cfg_pkg::ST_RACK;
              end else begin
                tx_ff        <= {tx_ff[6:0], 1'b1};
                sda_drive_ff <= ~tx_ff[6];
              end
            end
          end
          i2c_cfg_pkg::ST_RACK: begin
            if (scl_rise) begin
              master_ack_ff <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              if (master_ack_ff) begin
                tx_ff        <= i_rd_data;
                rd_req_ff    <= 1'b1;
                sda_drive_ff <= ~i_rd_data[7];
                state_ff     <= i2c_cfg_pkg::ST_RD;
              end else begin
                state_ff <= i2c_cfg_pkg::ST_IDLE;
              end
            end
          end
          default: state_ff <= i2c_cfg_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration register
  logic cfg_wr;                        // Configuration byte received
  logic setup_reset;                   // Setup byte with reset option
  assign cfg_wr = i_ce & ~stop_det & ~start_det & (state_ff == i2c_cfg_pkg::ST_WR) &
                  scl_fall & (bit_cnt_ff == 4'h8) & ~shift_ff[7];
  assign setup_reset = setup_wr_ff & ~setup_ff[`SETUP_BIT_RESET];

  // Stores configuration; a setup reset restores power-up value
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cfg_ff <= `CFG_RESET;
    end else if (i_ce) begin
      if (cfg_wr) begin
        cfg_ff <= shift_ff;
      end else if (setup_reset) begin
        cfg_ff <= `CFG_RESET;
      end
    end
  end

  // Field decode of the configuration byte
  always_comb begin
    o_cfg.scan         = i2c_cfg_pkg::scan_t'({cfg_ff[`CFG_BIT_SCAN_HI], cfg_ff[`CFG_BIT_SCAN_LO]});
    o_cfg.readback_en  = cfg_ff[`CFG_BIT_RB_HI] & cfg_ff[`CFG_BIT_RB_LO];
    o_cfg.chan         = {cfg_ff[`CFG_BIT_CH_HI], cfg_ff[`CFG_BIT_CH_LO]};
    o_cfg.single_ended = cfg_ff[`CFG_BIT_SE];
    o_cfg.unipolar     = cfg_ff[`CFG_BIT_SE] | ~setup_ff[`SETUP_BIT_POL];
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_sda                = 1'b0;
  assign o_sda_oe             = sda_drive_ff;
  assign o_hs_mode            = hs_ff;
  assign o_busy               = (state_ff != i2c_cfg_pkg::ST_IDLE);
  assign o_rd_req             = rd_req_ff;
  assign o_setup_wr           = setup_wr_ff;
  assign o_setup_byte         = setup_ff;
  assign o_conv_configuration = cfg_ff;
  assign o_mon_rate_free      = (o_cfg.scan == i2c_cfg_pkg::SCAN_MON);

  ////////////////////////////////////////////////////////////////////
  // Assertions
  property p_stop_fs;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_ce && stop_det) |=> !hs_ff;
  endproperty
  a_stop_fs: assert property (p_stop_fs) else $error("STOP did not restore fast timing");

  property p_hs_nack;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_ff == i2c_cfg_pkg::ST_ACK && hs_code_seen_ff) |-> !o_sda_oe;
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("Master code was acknowledged");

  property p_cfg_store;
    @(posedge i_clk_sys) disable iff (i_reset)
      cfg_wr |=> (cfg_ff == $past(shift_ff));
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("Configuration byte not stored");

  property p_setup_keep;
    @(posedge i_clk_sys) disable iff (i_reset)
      (setup_wr_ff && setup_ff[`SETUP_BIT_RESET]) |=> $stable(cfg_ff);
  endproperty
  a_setup_keep: assert property (p_setup_keep) else $error("Setup byte changed configuration");

  property p_reset_opt;
    @(posedge i_clk_sys) disable iff (i_reset)
      (setup_reset && !cfg_wr && i_ce) |=> (cfg_ff == `CFG_RESET);
  endproperty
  a_reset_opt: assert property (p_reset_opt) else $error("Setup reset did not restore configuration");

  property p_uni;
    @(posedge i_clk_sys) disable iff (i_reset)
      cfg_ff[`CFG_BIT_SE] |-> o_cfg.unipolar;
  endproperty
  a_uni: assert property (p_uni) else $error("Single-ended not unipolar");

  property p_rb;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_cfg.readback_en |-> (cfg_ff[4:3] == 2'h3);
  endproperty
  a_rb: assert property (p_rb) else $error("Readback enable wrong");

  property p_idle_quiet;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_ff == i2c_cfg_pkg::ST_IDLE) ##1 (state_ff == i2c_cfg_pkg::ST_IDLE) |-> !o_sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("SDA driven while idle");
endmodule

//--- include/i2c_cfg_params.svh
// Constants for the two-wire slave front end with configuration decoding
// Operation
// - Address low bit follows select pin
// - START plus matching address, then direction
// - Fast timing after power-up
// - High-speed master code is not acknowledged
// - High-speed timing after that not-acknowledge
// - STOP returns fast timing; repeated START keeps
// - Data byte MSB zero is configuration
// - Scan codes 00 and 01 decoded
// - Scan codes 10 and 11 decoded
// - Bits 4 and 3 enable setup readback
// - Bits 2:1 give channel or limit
// - Bit 0 selects single-ended or differential
// - Single-ended forces unipolar conversion
// - Monitor rate independent of bus speed
// - Data byte MSB one is setup
// - Setup reset option restores configuration
`ifndef I2C_CFG_PARAMS_SVH
`define I2C_CFG_PARAMS_SVH
`define ADDR_BASE        6'h1A
`define HS_CODE_TOP      5'h01
`define CFG_RESET        8'h01
`define CFG_BIT_SCAN_HI  6
`define CFG_BIT_SCAN_LO  5
`define CFG_BIT_RB_HI    4
`define CFG_BIT_RB_LO    3
`define CFG_BIT_CH_HI    2
`define CFG_BIT_CH_LO    1
`define CFG_BIT_SE       0
`define SETUP_BIT_RESET  1
`define SETUP_BIT_POL    2
`define FS_MAX_KHZ       400
`define HS_MAX_KHZ       1700
`define MON_MAX_KSPS     133
`endif

//--- include/i2c_cfg_pkg.sv
// Types for the two-wire slave front end
package i2c_cfg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100,
    ST_RACK = 3'b101
  } state_t;

  typedef enum logic [1:0] {
    SCAN_RANGE  = 2'b00,
    SCAN_REPEAT = 2'b01,
    SCAN_MON    = 2'b10,
    SCAN_SINGLE = 2'b11
  } scan_t;

  typedef struct packed {
    scan_t      scan;
    logic       readback_en;
    logic [1:0] chan;
    logic       single_ended;
    logic       unipolar;
  } conv_cfg_t;
endpackage

//--- tb/i2c_master_model.sv
// Behavioural two-wire bus master that drives the slave's bus clock and data
`timescale 1ns/100ps
module i2c_master_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_pull
);
  ////////////////////////////////////////////////////////////////
  // Bus idles released: clock driven high, data high on its pull-up
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  // A quarter of the 32 ns bus clock, stepped on the system falling edge
  task automatic quarter();
    repeat (2) @(negedge i_clk_sys);
  endtask

  // START or repeated START: data falls while the clock is high
  task automatic start();
    o_sda_pull = 1'b0;
    quarter();
    o_scl = 1'b1;
    quarter();
    o_sda_pull = 1'b1;
    quarter();
    o_scl = 1'b0;
    quarter();
  endtask

  // STOP: data rises while the clock is high, then the bus stands idle
  task automatic stop();
    o_sda_pull = 1'b1;
    quarter();
    o_scl = 1'b1;
    quarter();
    o_sda_pull = 1'b0;
    quarter();
    quarter();
  endtask

  // Eight bits MSB first plus the ninth slot; a one is sent by releasing
  task automatic xfer_byte(input logic [7:0] d_out, input logic ninth_out,
                           output logic [7:0] d_in, output logic ninth_in);
    logic [8:0] bits;
    bits = {d_out, ninth_out};
    for (int i = 8; i >= 0; i--) begin
      o_sda_pull = ~bits[i];
      quarter();
      o_scl = 1'b1;
      quarter();
      bits[i] = i_sda_line;
      quarter();
      o_scl = 1'b0;
      quarter();
    end
    d_in     = bits[8:1];
    ninth_in = bits[0];
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the two-wire slave with configuration decoding
`timescale 1ns/100ps
module tb_top;
  ////////////////////////////////////////////////////////////////
  logic                   i_clk_sys;          // System clock, 4 ns
  logic                   i_reset;            // Synchronous reset
  logic                   i_addr_select_pin;  // Address low bit level
  logic [7:0]             i_rd_data;          // Byte offered on reads
  logic                   scl;                // Bus clock from the master
  logic                   sda_pull;           // Master pulling data low
  logic                   sda_line;           // Resolved data wire
  logic                   o_sda;              // Slave data value
  logic                   o_sda_oe;           // Slave pulling data low
  logic                   o_hs_mode;          // High-speed timing flag
  logic                   o_busy;             // Slave not idle
  logic [7:0]             o_setup_byte;       // Last setup byte
  logic [7:0]             o_conv_configuration;
  i2c_cfg_pkg::conv_cfg_t o_cfg;              // Decoded configuration
  logic                   o_mon_rate_free;    // Monitor mode selected
  logic [7:0]             exp_cfg;            // Expected configuration
  logic [7:0]             exp_setup;          // Expected setup byte
  int                     num_errors;
  int                     n_tests;
  logic [7:0]             cfg_tab [0:3] = '{8'h1E, 8'h22, 8'h4D, 8'h7F};

  // Pull-up on the data wire, wired-AND of both parties
  assign sda_line = (o_sda_oe ? o_sda : 1'b1) & ~sda_pull;

  i2c_slave_cfg i2c_slave_cfg_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(1'b1), .i_scl(scl), .i_sda(sda_line),
    .i_addr_select_pin(i_addr_select_pin), .i_rd_data(i_rd_data), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .o_hs_mode(o_hs_mode), .o_busy(o_busy), .o_rd_req(),
    .o_setup_wr(), .o_setup_byte(o_setup_byte), .o_conv_configuration(o_conv_configuration),
    .o_cfg(o_cfg), .o_mon_rate_free(o_mon_rate_free)
  );

  i2c_master_model i2c_master_model_inst (
    .i_clk_sys(i_clk_sys), .i_sda_line(sda_line), .o_scl(scl), .o_sda_pull(sda_pull)
  );

  ////////////////////////////////////////////////////////////////
  // Free-running system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // One byte out; the ninth slot is released and its level compared
  task automatic put(input logic [7:0] b, input logic exp9);
    logic [7:0] r;
    logic       n;
    i2c_master_model_inst.xfer_byte(b, 1'b1, r, n);
    chk({7'h00, n}, {7'h00, exp9});
  endtask

  // Register and decoded fields against the expected bytes
  task automatic check_cfg();
    i2c_cfg_pkg::conv_cfg_t e;
    e.scan         = i2c_cfg_pkg::scan_t'(exp_cfg[6:5]);
    e.readback_en  = exp_cfg[4] & exp_cfg[3];
    e.chan         = exp_cfg[2:1];
    e.single_ended = exp_cfg[0];
    e.unipolar     = exp_cfg[0] | ~exp_setup[2];
    chk(o_conv_configuration, exp_cfg);
    chk({1'b0, o_cfg}, {1'b0, e});
    chk({7'h00, o_mon_rate_free}, {7'h00, exp_cfg[6:5] == 2'b10});
    chk(o_setup_byte, exp_setup);
  endtask

  // Write frame, optionally after the high-speed master code
  task automatic frame(input logic [7:0] b, input logic hs);
    i2c_master_model_inst.start();
    if (hs) begin
      put({5'h01, b[2:0]}, 1'b1);
      repeat (4) @(negedge i_clk_sys);
      chk({7'h00, o_hs_mode}, 8'h01);
      i2c_master_model_inst.start();
    end
    put({6'h1A, i_addr_select_pin, 1'b0}, 1'b0);
    put(b, 1'b0);
    chk({7'h00, o_hs_mode}, {7'h00, hs});
    i2c_master_model_inst.stop();
    repeat (8) @(negedge i_clk_sys);
    chk({7'h00, o_hs_mode}, 8'h00);
    // Setup bytes with the reset option low restore the power-up value
    if (b[7]) begin
      exp_setup = b;
      if (!b[1]) begin
        exp_cfg = 8'h01;
      end
    end else begin
      exp_cfg = b;
    end
    check_cfg();
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] r;
    logic       n;
    num_errors        = 0;
    n_tests           = 0;
    i_reset           = 1'b1;
    i_addr_select_pin = 1'b0;
    i_rd_data         = 8'h00;
    exp_cfg           = 8'h01;
    exp_setup         = 8'h00;
    repeat (5) @(negedge i_clk_sys);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    check_cfg();
    chk({7'h00, o_hs_mode}, 8'h00);
    // Every scan code, both address choices
    for (int k = 0; k < 4; k++) begin
      i_addr_select_pin = k[0];
      repeat (4) @(negedge i_clk_sys);
      frame(cfg_tab[k], 1'b0);
    end
    // Other address choice: ignored, idle, data byte not taken
    i2c_master_model_inst.start();
    put({6'h1A, ~i_addr_select_pin, 1'b0}, 1'b1);
    put(8'h55, 1'b1);
    chk({7'h00, o_busy}, 8'h00);
    i2c_master_model_inst.stop();
    check_cfg();
    frame(8'h55, 1'b0);
    // Setup byte, polarity against single-ended, then the reset option
    frame(8'h06, 1'b0);
    frame(8'hFE, 1'b0);
    frame(8'h07, 1'b0);
    frame(8'h80, 1'b0);
    // High-speed entry, kept over repeated START, left on STOP
    frame(8'h5A, 1'b1);
    frame(8'h3F, 1'b1);
    // Read transfer, master ends with a not-acknowledge
    i_rd_data = 8'hA5;
    i2c_master_model_inst.start();
    put({6'h1A, i_addr_select_pin, 1'b1}, 1'b0);
    i2c_master_model_inst.xfer_byte(8'hFF, 1'b1, r, n);
    chk(r, 8'hA5);
    i2c_master_model_inst.stop();
    repeat (8) @(negedge i_clk_sys);
    chk({7'h00, o_busy}, 8'h00);
    complete_run();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    num_errors++;
    complete_run();
  end
endmodule
